/* dbu_cfg.svh */
// Constants of the debug breakpoint unit: selectors, bit positions, resets.
// Assumes inclusion by bare name from every file that needs them.
//
// Overview of operation
// RULE1: Four debug registers, privileged load/store only.
// RULE2: Each condition active only while its bit is one.
// RULE3: Byte-lane bits select compared bytes of double-word.
// RULE4: Write references compared only with write enable.
// RULE5: Read compare needs read enable and master enable.
// RULE6: Trap enable makes enabled condition raise trap.
// RULE7: PC-match compares breakpoint register with PC.
// RULE8: Mode enables and global enable gate conditions.
// RULE9: Single-instruction bit stops pipeline overlap.
// RULE10: Prediction-off bit disables branch prediction.
// RULE11: Software keeps both test bits zero normally.
// RULE12: Detected condition sets its sticky status flag.
// RULE13: Read indicator loads one for read, zero write.
// RULE14: Read and write hit in one instruction: zero.
// RULE15: Only software clears the status flags.
// RULE16: Status may be undefined after pipelined FP trap.
// RULE17: Software keeps compare address double-word aligned.
// RULE18: Address compare watches operands, not instruction fetches.
// RULE19: Control bit layout: lanes, compares, test, enables.
// RULE20: Status layout: read, PC, external, address flags.
`ifndef DBU_CFG_SVH
`define DBU_CFG_SVH

// ********************************************************************
// Register selectors of the processor-register instructions
// ********************************************************************
`define DBU_SEL_CTL 2'h0
`define DBU_SEL_STS 2'h1
`define DBU_SEL_CAR 2'h2
`define DBU_SEL_BPC 2'h3

// ********************************************************************
// Control register bit positions
// ********************************************************************
`define DBU_CBE_HI  3
`define DBU_CBE_LO  0
`define DBU_CWR     5
`define DBU_CRD     6
`define DBU_CAE     7
`define DBU_SI      17
`define DBU_BCP     18
`define DBU_TR      19
`define DBU_PCE     20
`define DBU_UD      21
`define DBU_SD      22
`define DBU_DEN     23
`define DBU_CTL_MASK 32'h00FE00EF

// ********************************************************************
// Status register bit positions
// ********************************************************************
`define DBU_RD      31
`define DBU_PCH     30
`define DBU_EXT     29
`define DBU_ADR     28
`define DBU_STS_MASK 32'hF0000000

// ********************************************************************
// Address fields and reset values
// ********************************************************************
`define DBU_DW_HI   31
`define DBU_DW_LO   2
`define DBU_REG_RST 32'h00000000

`endif

/* dbu_lane_cmp.sv */
// Double-word address compare with per-lane byte selection.
// Assumes the operand lanes mark the bytes touched by the reference.
`include "dbu_cfg.svh"
`timescale 1ns/10ps
module dbu_lane_cmp #(
  parameter int LANES = 4
) (
  // Compare inputs
  input  wire logic [31:0]      cmp_addr,
  input  wire logic [LANES-1:0] lane_en,
  input  wire dbu_pkg::dbu_ref_type op_ref,
  // Result
  output logic                  hit
);

  logic [LANES-1:0] lane_hit;
  logic             dw_equal;

  // Same aligned double-word, low address bits ignored
  assign dw_equal = (op_ref.addr[`DBU_DW_HI:`DBU_DW_LO] ==
                     cmp_addr[`DBU_DW_HI:`DBU_DW_LO]);

  // One lane term per byte of the double-word
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_hit[i] = lane_en[i] & op_ref.lanes[i]; // RULE3
  end

  assign hit = dw_equal & (|lane_hit);

endmodule

/* dbu_pkg.sv */
// Types shared by the debug breakpoint unit modules.
// Assumes dbu_cfg.svh is available on the include path.
package dbu_pkg;

  // ******************************************************************
  // Operand reference presented by the execution pipeline
  // ******************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  lanes;
    logic        rd;
    logic        wr;
  } dbu_ref_type;

  // ******************************************************************
  // Register state of the top module
  // ******************************************************************
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] sts;
    logic [31:0] compare_address;
    logic [31:0] breakpoint_pc_address;
    logic [31:0] rdata;
    logic        trap;
    logic        inst_rd;
    logic        inst_wr;
    logic        ext_prev;
  } dbu_state_type;

  // ******************************************************************
  // Synchroniser stages
  // ******************************************************************
  typedef struct packed {
    logic meta;
    logic sync;
  } dbu_sync_type;

endpackage

/* dbu_sync.sv */
// Two-flip-flop synchroniser for the external debug condition pin.
// Assumes the pin is asynchronous to CLOCK.
`timescale 1ns/10ps
module dbu_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin and result
  input  wire logic pin,
  output logic      level
);

  dbu_pkg::dbu_sync_type s;
  dbu_pkg::dbu_sync_type next_s;

  // Shift the pin through two stages
  always_comb begin
    next_s.meta = pin;
    next_s.sync = s.meta;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.sync;

endmodule

/* dbu_top.sv */
// Debug breakpoint unit: four debug registers and condition detection.
// Assumes processor-register instruction strobes, PC and operand
// references all come from logic on CLOCK; the external condition is
// an asynchronous pin.
`include "dbu_cfg.svh"
`timescale 1ns/10ps
module dbu_top (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  // Processor-register load and store
  input  wire logic [1:0]  REG_SEL,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic        REG_PRIV,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  // Execution pipeline view
  input  wire logic        USER_MODE,
  input  wire logic        PC_VALID,
  input  wire logic [31:0] PC_ADDR,
  input  wire dbu_pkg::dbu_ref_type OP_REF,
  input  wire logic        INSTR_END,
  // External condition pin
  input  wire logic        EXT_COND,
  // Trap and test controls
  output logic             DEBUG_TRAP,
  output logic             SINGLE_INSTR,
  output logic             BRANCH_PREDICT_OFF
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  dbu_pkg::dbu_state_type s;
  dbu_pkg::dbu_state_type next_s;
  logic ext_level;
  logic lane_match;
  logic mode_ok;
  logic pc_hit;
  logic addr_hit;
  logic ext_hit;
  logic any_hit;
  logic ref_rd;
  logic ref_wr;
  logic rd_any;
  logic wr_any;
  logic wr_ok;
  logic rd_ok;

  // ******************************************************************
  // Helpers
  // ******************************************************************

  // External pin into the clock domain
  dbu_sync u_sync (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .pin   (EXT_COND),
    .level (ext_level)
  );

  // Operand address against the compare address register
  dbu_lane_cmp #(
    .LANES (4)
  ) u_cmp (
    .cmp_addr (s.compare_address),
    .lane_en  (s.ctl[`DBU_CBE_HI:`DBU_CBE_LO]),
    .op_ref   (OP_REF),
    .hit      (lane_match)
  );

  // ******************************************************************
  // Condition detection
  // ******************************************************************

  // Privileged accesses only
  assign wr_ok = REG_WR & REG_PRIV; // RULE1
  assign rd_ok = REG_RD & REG_PRIV; // RULE1

  // Global and privilege-mode gating
  assign mode_ok = s.ctl[`DBU_DEN] &
                   (USER_MODE ? s.ctl[`DBU_UD] : s.ctl[`DBU_SD]); // RULE8

  // Breakpoint PC equality
  assign pc_hit = mode_ok & s.ctl[`DBU_PCE] & PC_VALID &
                  (PC_ADDR == s.breakpoint_pc_address); // RULE7

  // Operand references filtered by direction
  assign ref_rd = OP_REF.rd & s.ctl[`DBU_CRD]; // RULE5
  assign ref_wr = OP_REF.wr & s.ctl[`DBU_CWR]; // RULE4

  // Operand address compare, fetches never reach this port
  assign addr_hit = mode_ok & s.ctl[`DBU_CAE] & lane_match &
                    (ref_rd | ref_wr); // RULE18

  // Rising edge of the synchronised external condition
  assign ext_hit = mode_ok & ext_level & ~s.ext_prev; // RULE2

  assign any_hit = pc_hit | addr_hit | ext_hit;

  // Read and write hits seen in this instruction so far
  assign rd_any = s.inst_rd | (addr_hit & ref_rd);
  assign wr_any = s.inst_wr | (addr_hit & ref_wr);

  // ******************************************************************
  // Next state
  // ******************************************************************

  // Register writes, sticky flags, trap and read data
  always_comb begin
    next_s = s;
    next_s.ext_prev = ext_level;
    next_s.trap = any_hit & s.ctl[`DBU_TR]; // RULE6
    next_s.rdata = `DBU_REG_RST;
    // Software writes of the debug registers
    if (wr_ok) begin
      unique case (REG_SEL)
        `DBU_SEL_CTL: begin
          next_s.ctl = REG_WDATA & `DBU_CTL_MASK; // RULE19
        end
        `DBU_SEL_STS: begin
          next_s.sts = REG_WDATA & `DBU_STS_MASK; // RULE15
        end
        `DBU_SEL_CAR: begin
          next_s.compare_address = REG_WDATA; // RULE17
        end
        `DBU_SEL_BPC: begin
          next_s.breakpoint_pc_address = REG_WDATA;
        end
      endcase
    end
    // Flags stay defined for every instruction kind
    // Hardware sets win over a clearing write
    if (pc_hit) begin
      next_s.sts[`DBU_PCH] = 1'b1; // RULE12
    end
    if (ext_hit) begin
      next_s.sts[`DBU_EXT] = 1'b1; // RULE12
    end
    if (addr_hit) begin
      next_s.sts[`DBU_ADR] = 1'b1; // RULE12 RULE16
      next_s.sts[`DBU_RD] = rd_any & ~wr_any; // RULE13 RULE14
    end
    // Per-instruction direction memory
    if (INSTR_END) begin
      next_s.inst_rd = 1'b0;
      next_s.inst_wr = 1'b0;
    end else begin
      next_s.inst_rd = rd_any;
      next_s.inst_wr = wr_any;
    end
    // Read data from the current register values
    if (rd_ok) begin
      unique case (REG_SEL)
        `DBU_SEL_CTL: begin
          next_s.rdata = s.ctl;
        end
        `DBU_SEL_STS: begin
          next_s.rdata = s.sts; // RULE20
        end
        `DBU_SEL_CAR: begin
          next_s.rdata = s.compare_address;
        end
        `DBU_SEL_BPC: begin
          next_s.rdata = s.breakpoint_pc_address;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  // All outputs straight from the state register
  assign REG_RDATA          = s.rdata;
  assign DEBUG_TRAP         = s.trap;
  assign SINGLE_INSTR       = s.ctl[`DBU_SI];  // RULE9
  assign BRANCH_PREDICT_OFF = s.ctl[`DBU_BCP]; // RULE10

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  // Unprivileged writes leave control alone
  a_priv_write: assert property ( // RULE1
    REG_WR && !REG_PRIV && !wr_ok |=> $stable(s.ctl))
    else $error("control changed by unprivileged write");

  // Global enable off: nothing detected
  a_global_gate: assert property ( // RULE2
    !s.ctl[`DBU_DEN] |-> !any_hit)
    else $error("condition hit with debug disabled");

  // Unselected lanes never match
  a_lane_mask: assert property ( // RULE3
    ((OP_REF.lanes & s.ctl[`DBU_CBE_HI:`DBU_CBE_LO]) == 4'h0)
      |-> !addr_hit)
    else $error("address hit on unselected lanes");

  // Writes need the write compare enable
  a_write_gate: assert property ( // RULE4
    OP_REF.wr && !OP_REF.rd && !s.ctl[`DBU_CWR] |-> !addr_hit)
    else $error("write compared while disabled");

  // Reads need read and master enables
  a_read_gate: assert property ( // RULE5
    OP_REF.rd && !OP_REF.wr &&
    !(s.ctl[`DBU_CRD] && s.ctl[`DBU_CAE]) |-> !addr_hit)
    else $error("read compared while disabled");

  // Trap one cycle after an enabled hit
  a_trap_raise: assert property ( // RULE6
    any_hit && s.ctl[`DBU_TR] |=> DEBUG_TRAP)
    else $error("trap not raised for hit");

  // No trap without trap enable
  a_trap_off: assert property ( // RULE6
    !$past(s.ctl[`DBU_TR]) |-> !DEBUG_TRAP)
    else $error("trap raised while disabled");

  // PC equality sets the PC flag
  a_pc_flag: assert property ( // RULE7
    mode_ok && s.ctl[`DBU_PCE] && PC_VALID && PC_ADDR == s.breakpoint_pc_address
      |=> s.sts[`DBU_PCH])
    else $error("PC match not flagged");

  // Disabled mode: nothing detected
  a_mode_gate: assert property ( // RULE8
    (USER_MODE && !s.ctl[`DBU_UD]) || (!USER_MODE && !s.ctl[`DBU_SD])
      |-> !any_hit)
    else $error("condition hit in disabled mode");

  // Privileged control write drives test outputs
  a_test_bits: assert property ( // RULE9
    wr_ok && REG_SEL == `DBU_SEL_CTL |=>
      SINGLE_INSTR == $past(REG_WDATA[`DBU_SI]) &&
      BRANCH_PREDICT_OFF == $past(REG_WDATA[`DBU_BCP]))
    else $error("test bits not loaded");

  // Read-only hit sets read indicator
  a_rd_read: assert property ( // RULE13
    addr_hit && rd_any && !wr_any |=> s.sts[`DBU_RD] && s.sts[`DBU_ADR])
    else $error("read indicator not set");

  // Any write hit in instruction clears it
  a_rd_both: assert property ( // RULE14
    addr_hit && wr_any |=> !s.sts[`DBU_RD])
    else $error("read indicator set after write hit");

  // Address flag stays until software writes status
  a_flag_sticky: assert property ( // RULE15
    s.sts[`DBU_ADR] && !(wr_ok && REG_SEL == `DBU_SEL_STS)
      |=> s.sts[`DBU_ADR])
    else $error("address flag lost");

  // Reserved status bits read as zero
  a_sts_layout: assert property ( // RULE20
    rd_ok && REG_SEL == `DBU_SEL_STS |=>
      (REG_RDATA & ~`DBU_STS_MASK) == 32'h00000000)
    else $error("reserved status bits nonzero");

  // Trap falls when no enabled hit came
  a_trap_pulse: assert property ( // RULE6
    !(any_hit && s.ctl[`DBU_TR]) |=> !DEBUG_TRAP)
    else $error("trap held without enabled hit");

  // External edge sets its flag
  a_ext_flag: assert property ( // RULE12
    ext_hit |=> s.sts[`DBU_EXT])
    else $error("external condition not flagged");

  // Address hit sets its flag
  a_adr_flag: assert property ( // RULE12
    addr_hit |=> s.sts[`DBU_ADR])
    else $error("address condition not flagged");

  // Read data returns to zero between reads
  a_rdata_idle: assert property ( // RULE1
    !rd_ok |=> REG_RDATA == 32'h00000000)
    else $error("read data left standing");

  // Breakpoint register read back whole
  a_bpc_read: assert property ( // RULE1
    rd_ok && REG_SEL == `DBU_SEL_BPC |=> REG_RDATA == $past(s.breakpoint_pc_address))
    else $error("breakpoint register read wrong");

  // Control read returns masked control
  a_ctl_read: assert property ( // RULE19
    rd_ok && REG_SEL == `DBU_SEL_CTL |=> REG_RDATA == $past(s.ctl))
    else $error("control register read wrong");

  // Reserved control bits stay zero
  a_ctl_layout: assert property ( // RULE19
    (s.ctl & ~`DBU_CTL_MASK) == 32'h00000000)
    else $error("reserved control bits nonzero");

  // No PC hit without its enable
  a_pc_gate: assert property ( // RULE7
    !s.ctl[`DBU_PCE] |-> !pc_hit)
    else $error("PC hit while disabled");

  // No operand reference, no address hit
  a_operand_only: assert property ( // RULE18
    !OP_REF.rd && !OP_REF.wr |-> !addr_hit)
    else $error("address hit without operand reference");

  // Instruction end forgets directions
  a_instr_clear: assert property ( // RULE14
    INSTR_END |=> !s.inst_rd && !s.inst_wr)
    else $error("direction memory kept past instruction end");

  // Test bits change only on control writes
  a_test_hold: assert property ( // RULE10
    !(wr_ok && REG_SEL == `DBU_SEL_CTL) |=>
      $stable(SINGLE_INSTR) && $stable(BRANCH_PREDICT_OFF))
    else $error("test bits changed without write");

  // PC flag stays until software writes status
  a_pc_sticky: assert property ( // RULE15
    s.sts[`DBU_PCH] && !(wr_ok && REG_SEL == `DBU_SEL_STS)
      |=> s.sts[`DBU_PCH])
    else $error("PC flag lost");

  // Status write without hit loads masked data
  a_sts_write: assert property ( // RULE15
    wr_ok && REG_SEL == `DBU_SEL_STS && !any_hit |=>
      s.sts == ($past(REG_WDATA) & `DBU_STS_MASK))
    else $error("status write not applied");

  c_pc_trap: cover property (pc_hit && s.ctl[`DBU_TR] ##1 DEBUG_TRAP);
  c_unpriv: cover property (REG_WR && !REG_PRIV);
  c_rd_wr: cover property (addr_hit && rd_any && wr_any);
  c_ext: cover property (ext_hit);
  c_clear: cover property (s.sts[`DBU_PCH] ##1 !s.sts[`DBU_PCH]);

endmodule

/* dbu_top_tb_top.sv */
// Self-checking bench for the debug breakpoint unit top.
// Assumes dbu_pkg is compiled first and dbu_cfg.svh is on the include path.
`include "dbu_cfg.svh"
`timescale 1ns/10ps
module dbu_top_tb_top;
  // ****
  // Signals and bench state
  // ****
  localparam logic [31:0] K_P   = 32'h00D80000;
  localparam logic [31:0] K_A   = 32'h00C8008F;
  localparam logic [31:0] K_CRD = 32'h00000040;
  localparam logic [31:0] K_CWR = 32'h00000020;
  logic                 CLOCK;
  logic                 RST_B;
  logic [1:0]           REG_SEL;
  logic                 REG_WR;
  logic                 REG_RD;
  logic                 REG_PRIV;
  logic [31:0]          REG_WDATA;
  logic [31:0]          REG_RDATA;
  logic                 USER_MODE;
  logic                 PC_VALID;
  logic [31:0]          PC_ADDR;
  dbu_pkg::dbu_ref_type OP_REF;
  dbu_pkg::dbu_ref_type nr;
  logic                 INSTR_END;
  logic                 EXT_COND;
  logic                 DEBUG_TRAP;
  logic                 SINGLE_INSTR;
  logic                 BRANCH_PREDICT_OFF;
  logic [31:0]          exp_q[$];
  logic [31:0]          msk[4];
  logic [31:0]          seed;
  logic [31:0]          a;
  logic [31:0]          b;
  logic                 rd_was;
  int                   n_errors;
  int                   comparisons;
  int                   i;

  dbu_top dut_u (
    .CLOCK(CLOCK), .RST_B(RST_B), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_PRIV(REG_PRIV), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .USER_MODE(USER_MODE), .PC_VALID(PC_VALID), .PC_ADDR(PC_ADDR), .OP_REF(OP_REF),
    .INSTR_END(INSTR_END), .EXT_COND(EXT_COND), .DEBUG_TRAP(DEBUG_TRAP),
    .SINGLE_INSTR(SINGLE_INSTR), .BRANCH_PREDICT_OFF(BRANCH_PREDICT_OFF)
  );

  // ****
  // Helpers
  // ****
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // One register port cycle; a read notes its expected answer
  task automatic go(input logic [1:0] s, input logic w, input logic r, input logic p,
                    input logic [31:0] d, input logic [31:0] e);
    REG_SEL = s;
    REG_WR = w;
    REG_RD = r;
    REG_PRIV = p;
    REG_WDATA = d;
    if (r) exp_q.push_back(e);
    @(posedge CLOCK);
    #1;
  endtask

  // Idle cycles
  task automatic idle(input int n);
    repeat (n) go(2'h0, 1'h0, 1'h0, 1'h1, 32'h0, 32'h0);
  endtask

  // Arm control, clear status, apply one cycle of events, check trap and status
  task automatic probe(input logic [31:0] c, input logic um, input logic pv,
                       input logic [31:0] pc, input dbu_pkg::dbu_ref_type rf,
                       input logic [31:0] es);
    go(`DBU_SEL_CTL, 1'h1, 1'h0, 1'h1, c, 32'h0);
    go(`DBU_SEL_STS, 1'h1, 1'h0, 1'h1, 32'h0, 32'h0);
    USER_MODE = um;
    PC_VALID = pv;
    PC_ADDR = pc;
    OP_REF = rf;
    INSTR_END = 1'h1;
    idle(1);
    check({31'h0, DEBUG_TRAP}, {31'h0, c[`DBU_TR] & (|es[30:28])});
    PC_VALID = 1'h0;
    OP_REF = nr;
    INSTR_END = 1'h0;
    go(`DBU_SEL_STS, 1'h0, 1'h1, 1'h1, 32'h0, es);
    check({31'h0, DEBUG_TRAP}, 32'h0);
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****
  // Clock, monitor and watchdog
  // ****
  // Clock generator
  initial begin
    CLOCK = 1'h0;
    forever #20 CLOCK = ~CLOCK;
  end

  // Read data checked the cycle after each read strobe
  always @(posedge CLOCK) begin
    rd_was = REG_RD;
    #2;
    if (rd_was === 1'h1) begin
      if (exp_q.size() == 0) begin
        check(REG_RDATA, 32'hFFFFFFFF);
      end else begin
        check(REG_RDATA, exp_q.pop_front());
      end
    end else begin
      check(REG_RDATA, 32'h0);
    end
  end

  // Hang limit
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_errors++;
    report_and_stop();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    RST_B = 1'h0;
    {REG_SEL, REG_WR, REG_RD, REG_PRIV, REG_WDATA} = '0;
    {USER_MODE, PC_VALID, PC_ADDR, INSTR_END, EXT_COND} = '0;
    nr = '0;
    OP_REF = nr;
    msk = '{`DBU_CTL_MASK, `DBU_STS_MASK, 32'hFFFFFFFF, 32'hFFFFFFFF};
    seed = 32'h0000BF38;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge CLOCK);
    #1;
    RST_B = 1'h1;
    for (i = 0; i < 4; i++) go(i[1:0], 1'h0, 1'h1, 1'h1, 32'h0, `DBU_REG_RST);
    go(`DBU_SEL_CTL, 1'h1, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h0);
    go(`DBU_SEL_CTL, 1'h0, 1'h1, 1'h1, 32'h0, 32'h0);
    // Random write, read back, unprivileged read
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      go(i[1:0], 1'h1, 1'h0, 1'h1, seed, 32'h0);
      if (i[1:0] == `DBU_SEL_CTL) begin
        check({30'h0, BRANCH_PREDICT_OFF, SINGLE_INSTR},
              {30'h0, seed[`DBU_BCP], seed[`DBU_SI]});
      end
      go(i[1:0], 1'h0, 1'h1, 1'h1, 32'h0, seed & msk[i[1:0]]);
      go(i[1:0], 1'h0, 1'h1, 1'h0, 32'h0, 32'h0);
    end
    // Program counter match cases
    b = xs(seed);
    go(`DBU_SEL_BPC, 1'h1, 1'h0, 1'h1, b, 32'h0);
    probe(K_P, 1'h0, 1'h1, b, nr, 32'h40000000);
    probe(K_P, 1'h0, 1'h1, b ^ 32'h80000000, nr, 32'h0);
    probe(K_P, 1'h0, 1'h0, b, nr, 32'h0);
    probe(K_P, 1'h1, 1'h1, b, nr, 32'h0);
    probe(K_P | 32'h00200000, 1'h1, 1'h1, b, nr, 32'h40000000);
    probe(K_P & ~32'h00800000, 1'h0, 1'h1, b, nr, 32'h0);
    probe(K_P & ~32'h00100000, 1'h0, 1'h1, b, nr, 32'h0);
    probe(K_P & ~32'h00080000, 1'h0, 1'h1, b, nr, 32'h40000000);
    // Operand address compare with every lane enable
    a = xs(b) & 32'hFFFFFFFC;
    seed = a;
    go(`DBU_SEL_CAR, 1'h1, 1'h0, 1'h1, a, 32'h0);
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      probe((K_A & ~32'hF) | K_CRD | {28'h0, i[3:0]}, 1'h0, 1'h0, a,
            '{a | {30'h0, seed[5:4]}, seed[3:0], 1'h1, 1'h0},
            (|(seed[3:0] & i[3:0])) ? 32'h90000000 : 32'h0);
    end
    probe(K_A | K_CWR, 1'h0, 1'h0, a, '{a, 4'hF, 1'h0, 1'h1}, 32'h10000000);
    probe(K_A | K_CRD, 1'h0, 1'h0, a, '{a, 4'hF, 1'h0, 1'h1}, 32'h0);
    probe(K_A | K_CWR, 1'h0, 1'h0, a, '{a, 4'hF, 1'h1, 1'h0}, 32'h0);
    probe((K_A & ~32'h80) | K_CRD, 1'h0, 1'h0, a, '{a, 4'hF, 1'h1, 1'h0}, 32'h0);
    probe(K_A | K_CRD | K_CWR, 1'h0, 1'h0, a, '{a, 4'hF, 1'h1, 1'h1}, 32'h10000000);
    probe(K_A | K_CRD, 1'h0, 1'h0, a, '{a ^ 32'h4, 4'hF, 1'h1, 1'h0}, 32'h0);
    probe(K_A | K_CRD, 1'h0, 1'h1, a, nr, 32'h0);
    probe(K_A | K_CRD, 1'h1, 1'h0, a, '{a, 4'hF, 1'h1, 1'h0}, 32'h0);
    // Flags stay until software clears them
    probe(K_A | K_CRD, 1'h0, 1'h0, a, '{a, 4'h1, 1'h1, 1'h0}, 32'h90000000);
    idle(4);
    go(`DBU_SEL_STS, 1'h0, 1'h1, 1'h1, 32'h0, 32'h90000000);
    go(`DBU_SEL_STS, 1'h1, 1'h0, 1'h1, 32'h0, 32'h0);
    go(`DBU_SEL_STS, 1'h0, 1'h1, 1'h1, 32'h0, 32'h0);
    // Read then write hit inside one instruction
    go(`DBU_SEL_CTL, 1'h1, 1'h0, 1'h1, K_A | K_CRD | K_CWR, 32'h0);
    go(`DBU_SEL_STS, 1'h1, 1'h0, 1'h1, 32'h0, 32'h0);
    OP_REF = '{a, 4'hF, 1'h1, 1'h0};
    idle(1);
    OP_REF = '{a, 4'hF, 1'h0, 1'h1};
    INSTR_END = 1'h1;
    idle(1);
    OP_REF = nr;
    INSTR_END = 1'h0;
    go(`DBU_SEL_STS, 1'h0, 1'h1, 1'h1, 32'h0, 32'h10000000);
    probe(K_A | K_CRD | K_CWR, 1'h0, 1'h0, a, '{a, 4'hF, 1'h1, 1'h0}, 32'h90000000);
    // External condition with and without the global enable
    for (i = 0; i < 2; i++) begin
      go(`DBU_SEL_CTL, 1'h1, 1'h0, 1'h1, (i == 1) ? 32'h00C80000 : 32'h00480000, 32'h0);
      go(`DBU_SEL_STS, 1'h1, 1'h0, 1'h1, 32'h0, 32'h0);
      EXT_COND = 1'h1;
      idle(5);
      go(`DBU_SEL_STS, 1'h0, 1'h1, 1'h1, 32'h0, (i == 1) ? 32'h20000000 : 32'h0);
      EXT_COND = 1'h0;
      idle(4);
    end
    // Mid-run reset clears every register and test output
    go(`DBU_SEL_CTL, 1'h1, 1'h0, 1'h1, 32'h00060000, 32'h0);
    check({30'h0, BRANCH_PREDICT_OFF, SINGLE_INSTR}, 32'h3);
    RST_B = 1'h0;
    idle(2);
    RST_B = 1'h1;
    check({30'h0, BRANCH_PREDICT_OFF, SINGLE_INSTR}, 32'h0);
    for (i = 0; i < 4; i++) go(i[1:0], 1'h0, 1'h1, 1'h1, 32'h0, `DBU_REG_RST);
    idle(2);
    check(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
